// ==== hw/ovd_pkg.sv ====
package ovd_pkg;

  // register index map on the plain register port
  localparam logic [7:0] ADDR_OV_CTRL      = 8'h6e;
  localparam logic [7:0] ADDR_SUPPLY       = 8'h70;
  localparam logic [7:0] ADDR_ELEC_TEMP    = 8'h71;
  localparam logic [7:0] ADDR_MOTOR_TEMP   = 8'h72;
  localparam logic [7:0] ADDR_REG_ERROR    = 8'h73;
  localparam logic [7:0] ADDR_REG_ERR_MAX  = 8'h74;
  localparam logic [7:0] ADDR_TORQUE_MAX   = 8'h75;
  localparam logic [7:0] ADDR_STATUS       = 8'h76;
  localparam logic [7:0] ADDR_STICKY       = 8'h77;
  localparam logic [7:0] ADDR_COND_SEL     = 8'h78;
  localparam logic [7:0] ADDR_CSTOP_SEL    = 8'h79;
  localparam logic [7:0] ADDR_HARDOFF_SEL  = 8'h7a;
  localparam logic [7:0] ADDR_MODE         = 8'h7b;
  localparam logic [7:0] ADDR_ERR_CODE     = 8'h7c;
  localparam logic [7:0] ADDR_LOCK_CURRENT = 8'h7d;

  // values after reset
  localparam logic [15:0] RST_OV_CTRL      = 16'h0000;
  localparam logic [15:0] RST_REG_ERR_MAX  = 16'h7fff;
  localparam logic [15:0] RST_TORQUE_MAX   = 16'h7fff;
  localparam logic [15:0] RST_COND_SEL     = 16'h0010;
  localparam logic [15:0] RST_MASK         = 16'h0000;
  localparam logic [15:0] RST_MODE         = 16'h0000;
  localparam logic [15:0] RST_LOCK_CURRENT = 16'h0100;

  // overvoltage control word fields
  localparam int OV_THR_LSB  = 0;
  localparam int OV_THR_W    = 10;
  localparam int OV_AUTO_BIT = 10;
  localparam int OV_ACT_LSB  = 12;

  // selection word fields
  localparam int SEL_A_LSB      = 0;
  localparam int SEL_B_LSB      = 4;
  localparam int SEL_FILTER_BIT = 8;

  // status word bit positions
  localparam int ST_FAIL    = 0;
  localparam int ST_COMM    = 1;
  localparam int ST_CURRENT = 2;
  localparam int ST_VOLTAGE = 3;
  localparam int ST_TEMP    = 4;
  localparam int ST_TORQUE  = 5;
  localparam int ST_LOCKED  = 6;
  localparam int ST_REGUL   = 7;
  localparam int ST_MOVING  = 8;
  localparam int ST_REVERSE = 9;
  localparam int ST_INPUT_A = 14;
  localparam int ST_INPUT_B = 15;

  // supply limits in 0.1 V, temperatures in degrees C
  localparam logic [15:0] SUPPLY_MIN_DV    = 16'h0064;
  localparam logic [15:0] SUPPLY_MAX_DV    = 16'h0226;
  localparam logic [15:0] DUMP_SPAN_DV     = 16'h0032;
  localparam logic [15:0] ELEC_TEMP_MAX_C  = 16'h0064;
  localparam logic [15:0] MOTOR_TEMP_MAX_C = 16'h0078;

  // timing
  localparam int CLK_HZ        = 50000000;
  localparam int PWM_FREQ_HZ   = 10000;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int BLINK_MS      = 250;
  localparam int BLINK_CYC     = (CLK_HZ / 1000) * BLINK_MS;
  localparam int FILTER_LEN    = 4;
  localparam int BLINK_GAP     = 4;

  // operating mode codes written into the mode register on a trip
  localparam logic [15:0] MODE_QUICKSTOP = 16'h0002;
  localparam logic [15:0] MODE_SHUTDOWN  = 16'h0003;

  typedef enum logic [1:0] {
    TRIP_NONE  = 2'b00,
    TRIP_QSTOP = 2'b01,
    TRIP_SHUT  = 2'b10
  } ovd_trip_type;

endpackage

// ==== hw/ovd_dump_trip.sv ====
// Functional notes
// - dump starts when supply exceeds threshold
// - dump pwm runs at fixed 10 kHz
// - duty linear over 5 V, saturates
// - threshold is 10-bit field, 0.1 V
// - zero threshold uses default maximum voltage
// - auto threshold bit may be ignored
// - action 1..4 picks output 1..4
// - overcurrent always trips shutdown
// - torque always clamped to settable maximum
// - supply voltage fault always trips shutdown
// - supply voltage always readable
// - overtemperature trips; both temperatures readable
// - current without motion sets locked bit
// - regulator error exposed, bit over maximum
// - live status follows its cause
// - sticky copy holds until software clears
// - two selected, filterable inputs in status
// - live and mask match enters failure
// - controlled stop: quickstop mode, steady green
// - hard off: current off, blink cause
// - error code top nibble is bit
`timescale 1ns/1ps
module ovd_dump_trip
  import ovd_pkg::*;
#(
  parameter int PWM_PERIOD = ovd_pkg::PWM_PERIOD_CYC,
  parameter int BLINK_DIV  = ovd_pkg::BLINK_CYC,
  parameter logic [15:0] DEFAULT_MAX_DV = 16'h01f4
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [15:0] supply_dv,
  input  wire logic [15:0] elec_temp_c,
  input  wire logic [15:0] motor_temp_c,
  input  wire logic        overcurrent,
  input  wire logic        internal_fail,
  input  wire logic        comm_error,
  input  wire logic [15:0] motor_current,
  input  wire logic        shaft_moving,
  input  wire logic        shaft_reverse,
  input  wire logic [15:0] reg_actual,
  input  wire logic [15:0] reg_target,
  input  wire logic [15:0] torque_request,
  input  wire logic [7:0]  digital_in,
  output logic [15:0]      torque_command,
  output logic             motor_enable,
  output logic             quick_stop_req,
  output logic             digital_output_1,
  output logic             digital_output_2,
  output logic             digital_output_3,
  output logic             digital_output_4,
  output logic             led_green,
  output logic             led_red
);
  import ovd_pkg::*;

  logic [15:0]   ov_ctrl_reg;
  logic [15:0]   reg_err_max_reg;
  logic [15:0]   torque_max_reg;
  logic [15:0]   cond_sel_reg;
  logic [15:0]   cstop_sel_reg;
  logic [15:0]   hardoff_sel_reg;
  logic [15:0]   mode_reg;
  logic [15:0]   lock_current_reg;
  logic [15:0]   sticky_condition_word_reg;
  logic [15:0]   err_code_reg;
  logic [15:0]   torque_reg;
  logic [15:0]   rdata_reg;
  logic [3:0]    dump_reg;
  logic          motor_off_reg;
  logic [12:0]   pwm_cnt_reg;
  logic [12:0]   on_cyc;
  logic [15:0]   threshold;
  logic [15:0]   excess;
  logic          over_thr;
  logic          dump_full;
  logic [3:0]    action;
  logic          action_dump;
  logic [15:0]   reg_diff;
  logic [15:0]   live_status;
  logic [15:0]   forced_mask;
  logic [15:0]   hardoff_hit;
  logic [15:0]   cstop_hit;
  logic [15:0]   clr_mask;
  logic [15:0]   sticky_keep;
  logic          mode_wr;
  logic          torque_limiting;
  logic [FILTER_LEN-1:0] hist_a_reg;
  logic [FILTER_LEN-1:0] hist_b_reg;
  logic          filt_a_reg;
  logic          filt_b_reg;
  logic          raw_a;
  logic          raw_b;
  logic          in_a;
  logic          in_b;
  ovd_trip_type  trip_reg;
  ovd_trip_type  trip_next;
  logic [3:0]    cause_reg;
  logic [24:0]   blink_div_reg;
  logic          blink_tick;
  logic [5:0]    blink_step_reg;

  // lowest set bit index, used for both trip kinds
  function automatic logic [3:0] first_bit(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // magnitude of a two's complement word
  function automatic logic [15:0] mag16(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  assign mode_wr  = reg_wr && (reg_addr == ADDR_MODE);
  assign clr_mask = (reg_wr && (reg_addr == ADDR_STICKY)) ? reg_wdata : 16'h0000;

  // threshold select; auto bit left unused, feature not available
  assign threshold = (ov_ctrl_reg[OV_THR_LSB +: OV_THR_W] == 10'h000) ? DEFAULT_MAX_DV
                   : {6'h00, ov_ctrl_reg[OV_THR_LSB +: OV_THR_W]};
  assign over_thr    = supply_dv > threshold;
  assign excess      = over_thr ? 16'(supply_dv - threshold) : 16'h0000;
  assign dump_full   = excess >= DUMP_SPAN_DV;
  assign action      = ov_ctrl_reg[OV_ACT_LSB +: 4];
  assign action_dump = (action >= 4'h1) && (action <= 4'h4);

  // on-time grows by one span step per 0.1 V above threshold
  always_comb begin
    if (dump_full) begin
      on_cyc = 13'(PWM_PERIOD);
    end else begin
      on_cyc = 13'(excess * 16'(PWM_PERIOD / 50));
    end
  end

  // free running pwm period counter, independent of supply
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwm_cnt_reg <= 13'h0000;
    end else if (pwm_cnt_reg == 13'(PWM_PERIOD - 1)) begin
      pwm_cnt_reg <= 13'h0000;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 13'h0001;
    end
  end

  // dump drive routed to the chosen output, off otherwise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dump_reg <= 4'h0;
    end else if (over_thr && action_dump && (pwm_cnt_reg < on_cyc)) begin
      dump_reg <= 4'(4'h1 << (action - 4'h1));
    end else begin
      dump_reg <= 4'h0;
    end
  end

  // action zero: motor switched off while the supply is too high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      motor_off_reg <= 1'b0;
    end else begin
      motor_off_reg <= over_thr && (action == 4'h0);
    end
  end

  assign digital_output_1 = dump_reg[0];
  assign digital_output_2 = dump_reg[1];
  assign digital_output_3 = dump_reg[2];
  assign digital_output_4 = dump_reg[3];

  // torque clamp, signed request against unsigned maximum
  always_comb begin
    torque_limiting = 1'b0;
    if (!torque_request[15] && (torque_request > torque_max_reg)) begin
      torque_limiting = 1'b1;
    end else if (torque_request[15] && (mag16(torque_request) > torque_max_reg)) begin
      torque_limiting = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      torque_reg <= 16'h0000;
    end else if (!torque_limiting) begin
      torque_reg <= torque_request;
    end else if (torque_request[15]) begin
      torque_reg <= 16'(-torque_max_reg);
    end else begin
      torque_reg <= torque_max_reg;
    end
  end
  assign torque_command = (trip_reg == TRIP_SHUT) ? 16'h0000 : torque_reg;

  // input select; filter needs the level stable for a few cycles
  assign raw_a = digital_in[cond_sel_reg[SEL_A_LSB +: 3]];
  assign raw_b = digital_in[cond_sel_reg[SEL_B_LSB +: 3]];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hist_a_reg <= '0;
      hist_b_reg <= '0;
      filt_a_reg <= 1'b0;
      filt_b_reg <= 1'b0;
    end else begin
      hist_a_reg <= {hist_a_reg[FILTER_LEN-2:0], raw_a};
      hist_b_reg <= {hist_b_reg[FILTER_LEN-2:0], raw_b};
      if (&hist_a_reg) filt_a_reg <= 1'b1;
      if (~|hist_a_reg) filt_a_reg <= 1'b0;
      if (&hist_b_reg) filt_b_reg <= 1'b1;
      if (~|hist_b_reg) filt_b_reg <= 1'b0;
    end
  end
  assign in_a = cond_sel_reg[SEL_FILTER_BIT] ? filt_a_reg : raw_a;
  assign in_b = cond_sel_reg[SEL_FILTER_BIT] ? filt_b_reg : raw_b;

  assign reg_diff = 16'(reg_actual - reg_target);

  // live status: pure function of present causes, except filtered input bits, which come from the registered filter
  always_comb begin
    live_status             = 16'h0000;
    live_status[ST_FAIL]    = internal_fail;
    live_status[ST_COMM]    = comm_error;
    live_status[ST_CURRENT] = overcurrent;
    live_status[ST_VOLTAGE] = (supply_dv < SUPPLY_MIN_DV) || (supply_dv > SUPPLY_MAX_DV);
    live_status[ST_TEMP]    = (elec_temp_c > ELEC_TEMP_MAX_C) || (motor_temp_c > MOTOR_TEMP_MAX_C);
    live_status[ST_TORQUE]  = torque_limiting;
    live_status[ST_LOCKED]  = (mag16(motor_current) > lock_current_reg) && !shaft_moving;
    live_status[ST_REGUL]   = mag16(reg_diff) > reg_err_max_reg;
    live_status[ST_MOVING]  = shaft_moving;
    live_status[ST_REVERSE] = shaft_reverse;
    live_status[ST_INPUT_A] = in_a;
    live_status[ST_INPUT_B] = in_b;
  end

  // current, voltage and temperature trip regardless of any mask
  always_comb begin
    forced_mask             = 16'h0000;
    forced_mask[ST_CURRENT] = 1'b1;
    forced_mask[ST_VOLTAGE] = 1'b1;
    forced_mask[ST_TEMP]    = 1'b1;
  end
  assign hardoff_hit = live_status & (hardoff_sel_reg | forced_mask);
  assign cstop_hit   = live_status & cstop_sel_reg;

  // sticky word: new events win over a clear in the same cycle
  assign sticky_keep = sticky_condition_word_reg & ~clr_mask;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sticky_condition_word_reg <= 16'h0000;
    end else begin
      sticky_condition_word_reg <= sticky_keep | live_status;
    end
  end

  // hard off outranks controlled stop and a mode write; else a mode write releases the trip
  always_comb begin
    trip_next = trip_reg;
    if (|hardoff_hit) begin
      trip_next = TRIP_SHUT;
    end else if (mode_wr) begin
      trip_next = TRIP_NONE;
    end else if ((|cstop_hit) && (trip_reg == TRIP_NONE)) begin
      trip_next = TRIP_QSTOP;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      trip_reg <= TRIP_NONE;
    end else begin
      trip_reg <= trip_next;
    end
  end

  // cause and error code captured on entry to a trip
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cause_reg    <= 4'h0;
      err_code_reg <= 16'h0000;
    end else if ((trip_next == TRIP_SHUT) && (trip_reg != TRIP_SHUT)) begin
      cause_reg    <= first_bit(hardoff_hit);
      err_code_reg <= {first_bit(hardoff_hit), 12'h001};
    end else if ((trip_next == TRIP_QSTOP) && (trip_reg == TRIP_NONE)) begin
      cause_reg    <= first_bit(cstop_hit);
      err_code_reg <= {first_bit(cstop_hit), 12'h001};
    end
  end

  assign motor_enable   = (trip_reg != TRIP_SHUT) && !motor_off_reg;
  assign quick_stop_req = (trip_reg == TRIP_QSTOP);

  // blink tick divider, slow rate kept as an enable
  always_ff @(posedge core_clk) begin
    if (srst || (blink_div_reg == 25'(BLINK_DIV - 1))) begin
      blink_div_reg <= 25'h0000000;
    end else begin
      blink_div_reg <= blink_div_reg + 25'h0000001;
    end
  end
  assign blink_tick = (blink_div_reg == 25'(BLINK_DIV - 1));

  // blink cause+1 flashes, then a dark gap, then repeat
  always_ff @(posedge core_clk) begin
    if (srst || (trip_reg != TRIP_SHUT)) begin
      blink_step_reg <= 6'h00;
    end else if (blink_tick) begin
      if (blink_step_reg >= 6'({cause_reg, 1'b0} + 6'd2 + 6'(BLINK_GAP) - 6'd1)) begin
        blink_step_reg <= 6'h00;
      end else begin
        blink_step_reg <= blink_step_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      led_green <= 1'b0;
      led_red   <= 1'b0;
    end else begin
      led_green <= (trip_reg != TRIP_SHUT);
      led_red   <= (trip_reg == TRIP_SHUT) && !blink_step_reg[0]
                   && (blink_step_reg < 6'({cause_reg, 1'b0} + 6'd2));
    end
  end

  // software writable registers; a trip overrides the mode word
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ov_ctrl_reg      <= RST_OV_CTRL;
      reg_err_max_reg  <= RST_REG_ERR_MAX;
      torque_max_reg   <= RST_TORQUE_MAX;
      cond_sel_reg     <= RST_COND_SEL;
      cstop_sel_reg    <= RST_MASK;
      hardoff_sel_reg  <= RST_MASK;
      lock_current_reg <= RST_LOCK_CURRENT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_OV_CTRL:      ov_ctrl_reg      <= reg_wdata;
        ADDR_REG_ERR_MAX:  reg_err_max_reg  <= reg_wdata;
        ADDR_TORQUE_MAX:   torque_max_reg   <= {1'b0, reg_wdata[14:0]};
        ADDR_COND_SEL:     cond_sel_reg     <= reg_wdata;
        ADDR_CSTOP_SEL:    cstop_sel_reg    <= reg_wdata;
        ADDR_HARDOFF_SEL:  hardoff_sel_reg  <= reg_wdata;
        ADDR_LOCK_CURRENT: lock_current_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_reg <= RST_MODE;
    end else if ((trip_next == TRIP_SHUT) && (trip_reg != TRIP_SHUT)) begin
      mode_reg <= MODE_SHUTDOWN;
    end else if ((trip_next == TRIP_QSTOP) && (trip_reg == TRIP_NONE)) begin
      mode_reg <= MODE_QUICKSTOP;
    end else if (mode_wr) begin
      // a live unmaskable fault keeps the shutdown code over any write
      mode_reg <= (trip_next == TRIP_SHUT) ? MODE_SHUTDOWN : reg_wdata;
    end
  end

  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_OV_CTRL:      rdata_reg <= ov_ctrl_reg;
        ADDR_SUPPLY:       rdata_reg <= supply_dv;
        ADDR_ELEC_TEMP:    rdata_reg <= elec_temp_c;
        ADDR_MOTOR_TEMP:   rdata_reg <= motor_temp_c;
        ADDR_REG_ERROR:    rdata_reg <= reg_diff;
        ADDR_REG_ERR_MAX:  rdata_reg <= reg_err_max_reg;
        ADDR_TORQUE_MAX:   rdata_reg <= torque_max_reg;
        ADDR_STATUS:       rdata_reg <= live_status;
        ADDR_STICKY:       rdata_reg <= sticky_condition_word_reg;
        ADDR_COND_SEL:     rdata_reg <= cond_sel_reg;
        ADDR_CSTOP_SEL:    rdata_reg <= cstop_sel_reg;
        ADDR_HARDOFF_SEL:  rdata_reg <= hardoff_sel_reg;
        ADDR_MODE:         rdata_reg <= mode_reg;
        ADDR_ERR_CODE:     rdata_reg <= err_code_reg;
        ADDR_LOCK_CURRENT: rdata_reg <= lock_current_reg;
        default:           rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_reg;

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  property p_dump_off;
    !(over_thr && action_dump) |=> (dump_reg == 4'h0);
  endproperty
  a_dump_off: assert property (p_dump_off) else $error("dump active outside conditions");

  property p_pwm_wrap;
    (pwm_cnt_reg == 13'(PWM_PERIOD - 1)) |=> (pwm_cnt_reg == 13'h0000);
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm period wrong");

  sequence s_full_dump;
    (dump_full && action == 4'h1)[*2];
  endsequence
  property p_full_duty;
    s_full_dump |-> digital_output_1;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty not reached");

  property p_overcurrent;
    overcurrent |=> (trip_reg == TRIP_SHUT) && !motor_enable;
  endproperty
  a_overcurrent: assert property (p_overcurrent) else $error("overcurrent did not trip");

  property p_voltage;
    (supply_dv > SUPPLY_MAX_DV) |=> (trip_reg == TRIP_SHUT) ##0 (mode_reg == MODE_SHUTDOWN);
  endproperty
  a_voltage: assert property (p_voltage) else $error("supply fault did not trip");

  property p_sticky;
    1'b1 |=> ((sticky_condition_word_reg & $past(sticky_keep)) == $past(sticky_keep));
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit lost");

  property p_stay;
    (trip_reg != TRIP_NONE) && !mode_wr |=> (trip_reg != TRIP_NONE);
  endproperty
  a_stay: assert property (p_stay) else $error("trip released without mode write");

  property p_supply_read;
    reg_rd && (reg_addr == ADDR_SUPPLY) |=> (reg_rdata == $past(supply_dv));
  endproperty
  a_supply_read: assert property (p_supply_read) else $error("supply read wrong");

  property p_err_code;
    (trip_reg == TRIP_NONE) && (|hardoff_hit) |=> (err_code_reg[15:12] == cause_reg);
  endproperty
  a_err_code: assert property (p_err_code) else $error("error code nibble wrong");

endmodule // ovd_dump_trip

// ==== verif/ovd_resistor_model.sv ====
`timescale 1ns/1ps
// dump resistor load: counts conduction cycles of the switch behind each output
module ovd_resistor_model (
  input  wire logic        core_clk,
  input  wire logic        clr,
  input  wire logic [3:0]  gate,
  output logic      [15:0] on_cnt [4]
);
  // heat only flows while a gate is high; clear opens a fresh window
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      on_cnt[i] <= clr ? 16'h0000 : on_cnt[i] + {15'h0000, gate[i]};
    end
  end
endmodule // ovd_resistor_model

// ==== verif/ovd_dump_trip_bench.sv ====
`timescale 1ns/1ps
module ovd_dump_trip_bench;
  import ovd_pkg::*;
  localparam int P = 100;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, clr = 0;
  logic [7:0]  reg_addr = 8'h00, digital_in = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, supply_dv = 16'h00fa, torque_command;
  logic [15:0] elec_temp_c = 16'h0019, motor_temp_c = 16'h0019, motor_current = 16'h0000;
  logic [15:0] reg_actual = 16'h0000, reg_target = 16'h0000, torque_request = 16'h0000;
  logic        overcurrent = 0, internal_fail = 0, comm_error = 0, shaft_moving = 0, shaft_reverse = 0;
  logic        motor_enable, quick_stop_req, led_green, led_red;
  wire logic [3:0] outs;
  logic [15:0] on_cnt [4];
  int          mismatches = 0, cmp_count = 0;
  int          tq, red_cnt;

  ovd_dump_trip #(.PWM_PERIOD(P), .BLINK_DIV(4)) uut (.core_clk(core_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .supply_dv(supply_dv), .elec_temp_c(elec_temp_c), .motor_temp_c(motor_temp_c), .overcurrent(overcurrent),
    .internal_fail(internal_fail), .comm_error(comm_error), .motor_current(motor_current),
    .shaft_moving(shaft_moving), .shaft_reverse(shaft_reverse), .reg_actual(reg_actual),
    .reg_target(reg_target), .torque_request(torque_request), .digital_in(digital_in),
    .torque_command(torque_command), .motor_enable(motor_enable), .quick_stop_req(quick_stop_req),
    .digital_output_1(outs[0]), .digital_output_2(outs[1]), .digital_output_3(outs[2]),
    .digital_output_4(outs[3]), .led_green(led_green), .led_red(led_red));
  ovd_resistor_model load (.core_clk(core_clk), .clr(clr), .gate(outs), .on_cnt(on_cnt));

  // 50 MHz core clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one-cycle strobes; read data stands only in the following cycle
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string m);
    @(posedge core_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge core_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, m);
  endtask
  // reference duty: on-cycles per period from threshold, supply and action
  function automatic int exp_on(int thr, int sup, int act);
    int t, e;
    t = ((thr % 1024) == 0) ? 500 : (thr % 1024); // auto and spare bits are not threshold
    e = sup - t;
    if (act < 1 || act > 4 || e <= 0) return 0;
    return ((e > 50) ? 50 : e) * (P / 50);
  endfunction
  // settle two periods, then count one full window on every output
  task automatic dump(input int thr, input int sup, input int act);
    wr(ADDR_OV_CTRL, 16'(act << 12) | 16'(thr));
    supply_dv <= 16'(sup);
    repeat (2 * P) @(posedge core_clk);
    @(posedge core_clk) clr <= 1'b1;
    @(posedge core_clk) clr <= 1'b0;
    repeat (P) @(posedge core_clk);
    #1;
    for (int i = 0; i < 4; i++) begin
      chk(on_cnt[i], 16'((i == act - 1) ? exp_on(thr, sup, act) : 0), "dump duty");
    end
    $display("dump test thr %0d supply %0d action %0d done", thr, sup, act);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog sized well above the whole sequence
  initial begin
    #(20 * 20000);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(72668));
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    rd(ADDR_OV_CTRL, RST_OV_CTRL, "ov ctrl reset");
    rd(ADDR_COND_SEL, RST_COND_SEL, "select reset");
    rd(8'hff, 16'h0000, "unmapped read");
    @(posedge core_clk) supply_dv <= 16'(150 + $urandom % 300);
    @(posedge core_clk);
    rd(ADDR_SUPPLY, supply_dv, "supply readback");
    $display("register test done");
    for (int a = 1; a <= 4; a++) dump(260, 260 + $urandom % 61, a);
    dump(260, 260, 2);
    dump(260, 315, 3);
    dump(0, 510, 1);
    dump(260, 280, 5);
    dump(1284, 280, 4);
    // action zero: motor drops above threshold, returns below it
    wr(ADDR_OV_CTRL, 16'h0104);
    supply_dv <= 16'h012c;
    repeat (3) @(posedge core_clk);
    #1 chk(16'(motor_enable), 16'h0000, "motor off at threshold");
    @(posedge core_clk) supply_dv <= 16'h00fa;
    repeat (3) @(posedge core_clk);
    #1 chk(16'(motor_enable), 16'h0001, "motor back on");
    $display("action zero test done");
    // live causes: locked shaft, regulator error, two raw selected inputs
    wr(ADDR_REG_ERR_MAX, 16'h0010);
    {motor_current, reg_actual, digital_in} <= {16'h0200, 16'h0020, 8'h03};
    @(posedge core_clk);
    tq = (1 << ST_LOCKED) | (1 << ST_REGUL) | (1 << ST_INPUT_A) | (1 << ST_INPUT_B);
    rd(ADDR_STATUS, 16'(tq), "live causes");
    rd(ADDR_REG_ERROR, 16'h0020, "regulator difference");
    // torque clamp against a small maximum, both signs
    @(posedge core_clk) {motor_current, reg_actual, digital_in} <= '0;
    wr(ADDR_TORQUE_MAX, 16'h0100);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk) torque_request <= 16'($urandom);
      repeat (2) @(posedge core_clk);
      #1 tq = $signed(torque_request);
      chk(torque_command, 16'((tq > 256) ? 256 : ((tq < -256) ? -256 : tq)), "torque clamp");
    end
    @(posedge core_clk) torque_request <= 16'h0080;
    wr(ADDR_STICKY, 16'hffff);
    $display("status and torque test done");
    // unmaskable overcurrent pulse: trip holds after cause is gone
    @(posedge core_clk) overcurrent <= 1'b1;
    repeat (3) @(posedge core_clk) overcurrent <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk(16'({motor_enable, led_green}), 16'h0000, "shutdown current off");
    chk(torque_command, 16'h0000, "shutdown torque zero");
    // one full blink lap: cause+1 flashes of one tick each
    red_cnt = 0;
    for (int k = 0; k < (2 * (ST_CURRENT + 1) + BLINK_GAP) * 4; k++) begin
      @(posedge core_clk);
      #1 red_cnt += led_red;
    end
    chk(16'(red_cnt), 16'((ST_CURRENT + 1) * 4), "blink count");
    rd(ADDR_MODE, MODE_SHUTDOWN, "shutdown mode");
    rd(ADDR_ERR_CODE, {4'(ST_CURRENT), 12'h001}, "error code cause");
    rd(ADDR_STATUS, 16'h0000, "live status dropped");
    rd(ADDR_STICKY, 16'h0004, "sticky holds");
    wr(ADDR_STICKY, 16'h0004);
    rd(ADDR_STICKY, 16'h0000, "sticky cleared");
    wr(ADDR_MODE, 16'h0000);
    repeat (2) @(posedge core_clk);
    #1 chk(16'(motor_enable), 16'h0001, "released by mode write");
    chk(torque_command, 16'h0080, "torque restored");
    $display("shutdown test done");
    // masked-in comm fault takes the controlled stop path
    wr(ADDR_CSTOP_SEL, 16'h0002);
    comm_error <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk(16'({quick_stop_req, led_green, motor_enable}), 16'h0007, "controlled stop");
    rd(ADDR_MODE, MODE_QUICKSTOP, "quickstop mode");
    $display("controlled stop test done");
    // supply fault outranks the controlled stop and a later mode write
    @(posedge core_clk) supply_dv <= 16'(SUPPLY_MAX_DV + 1 + $urandom % 100);
    repeat (3) @(posedge core_clk);
    #1 chk(16'({quick_stop_req, motor_enable}), 16'h0000, "supply fault current off");
    rd(ADDR_ERR_CODE, {4'(ST_VOLTAGE), 12'h001}, "supply fault code");
    wr(ADDR_MODE, 16'h0000);
    rd(ADDR_MODE, MODE_SHUTDOWN, "shutdown holds");
    $display("supply fault test done");
    test_done();
  end
endmodule // ovd_dump_trip_bench
